// [hdl/gpp_port.sv]
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module gpp_port
    import gpp_pkg::*;
#(
    parameter int NPINS = GPP_PINS,
    parameter int NGRP = 2,
    // group index per pin, 2 bits each, pin 0 lowest
    // a group at or above NGRP leaves that pin without interrupt
    parameter logic [15:0] GRP_MAP = 16'haa00
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_pullup_en,
    input wire logic [NPINS-1:0] alt_out_en,
    input wire logic [NPINS-1:0] alt_out,
    input wire logic [NPINS-1:0] alt_open_drain,
    output logic [NPINS-1:0] alt_in,
    input wire logic cpu_irq_mask,
    input wire logic [NGRP-1:0] vector_fetch,
    output logic [NGRP-1:0] ext_irq_req
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NPINS < 1 || NPINS > GPP_PINS)
    begin : g_bad_pins
        $error("pin count must be 1 to 8");
    end
    if (NGRP < 1 || NGRP > 4)
    begin : g_bad_groups
        $error("group count must be 1 to 4");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [NPINS-1:0] pin_data_q;
    logic [NPINS-1:0] pin_direction_q;
    logic [NPINS-1:0] pin_option_q;
    logic [7:0] ext_irq_sensitivity_ctrl_q;
    logic [NPINS-1:0] pin_sync;
    logic [NPINS-1:0] pin_prev_q;
    logic [NGRP-1:0] irq_pend_q;
    logic [NGRP-1:0] irq_d;
    logic [NPINS-1:0] data_view;
    logic sens_wr;
    logic [2:0] settle_q;

    gpp_pin_sync #(.WIDTH(NPINS)) u_sync
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // latch always written, pin only driven when output
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_data_q <= '0;
        else if (wr_en && addr == GPP_ADDR_DATA)
            pin_data_q <= wdata[NPINS-1:0];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_direction_q <= GPP_RST_BYTE[NPINS-1:0];
            pin_option_q <= GPP_RST_BYTE[NPINS-1:0];
            ext_irq_sensitivity_ctrl_q <= GPP_RST_BYTE;
        end
        else if (wr_en)
        begin
            if (addr == GPP_ADDR_DIR)
                pin_direction_q <= wdata[NPINS-1:0];
            if (addr == GPP_ADDR_OPT)
                pin_option_q <= wdata[NPINS-1:0];
            if (addr == GPP_ADDR_SENS)
                ext_irq_sensitivity_ctrl_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // pad control
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            if (alt_out_en[i])
            begin
                // peripheral wins over register setup
                pin_out[i] = alt_out[i] & ~alt_open_drain[i];
                pin_oe[i] = ~alt_open_drain[i] | ~alt_out[i];
                pin_pullup_en[i] = 1'b0;
            end
            else if (pin_direction_q[i])
            begin
                pin_out[i] = pin_data_q[i] & pin_option_q[i];
                pin_oe[i] = pin_option_q[i] | ~pin_data_q[i];
                pin_pullup_en[i] = 1'b0;
            end
            else
            begin
                pin_out[i] = 1'b0;
                pin_oe[i] = 1'b0;
                pin_pullup_en[i] = pin_option_q[i];
            end
            // input pin feeds level, output pin feeds latch
            alt_in[i] = pin_direction_q[i] ? pin_data_q[i]
                                           : pin_sync[i];
            if (pin_direction_q[i])
                data_view[i] = pin_data_q[i];
            else if (alt_out_en[i])
                data_view[i] = alt_out[i];
            else
                data_view[i] = pin_sync[i];
        end
    end

    // ------------------------------------------------------------
    // register read, data one cycle after strobe
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (rd_en)
        begin
            rdata <= '0;
            case (addr)
                GPP_ADDR_DATA: rdata[NPINS-1:0] <= data_view;
                GPP_ADDR_DIR: rdata[NPINS-1:0] <= pin_direction_q;
                GPP_ADDR_OPT: rdata[NPINS-1:0] <= pin_option_q;
                GPP_ADDR_SENS: rdata <= ext_irq_sensitivity_ctrl_q;
                default: rdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // external interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_prev_q <= '0;
        else
            pin_prev_q <= pin_sync;
    end

    // no edge judged until sync and prev hold real pin levels
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            settle_q <= '0;
        else
            settle_q <= {settle_q[1:0], 1'b1};
    end

    assign sens_wr = wr_en && addr == GPP_ADDR_SENS;

    always_comb
    begin
        logic [1:0] s;
        logic ev;
        int g;
        s = GPP_SENS_FALL_LOW;
        ev = 1'b0;
        g = 0;
        irq_d = '0;
        for (int i = 0; i < NPINS; i++)
        begin
            g = int'(GRP_MAP[2*i +: 2]);
            s = ext_irq_sensitivity_ctrl_q[2*(g % 4) +: 2];
            case (s)
                GPP_SENS_FALL_LOW: ev = ~pin_sync[i];
                GPP_SENS_RISE: ev = pin_sync[i] & ~pin_prev_q[i];
                GPP_SENS_FALL: ev = ~pin_sync[i] & pin_prev_q[i];
                GPP_SENS_BOTH: ev = pin_sync[i] ^ pin_prev_q[i];
                default: ev = 1'b0;
            endcase
            // only input with interrupt (option set) pins count
            if (!pin_direction_q[i] && pin_option_q[i] && ev
                && g < NGRP && settle_q[2])
                irq_d[g] = 1'b1;
        end
    end

    // software cannot see the latch; new event beats clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_pend_q <= '0;
        else
        begin
            for (int k = 0; k < NGRP; k++)
            begin
                if (irq_d[k])
                    irq_pend_q[k] <= 1'b1;
                else if (vector_fetch[k] || sens_wr)
                    irq_pend_q[k] <= 1'b0;
            end
        end
    end

    assign ext_irq_req = irq_pend_q & {NGRP{~cpu_irq_mask}};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_input_undriven: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (pin_oe & ~pin_direction_q & ~alt_out_en) == '0)
        else $error("input pin driven");
    a_od_high_released: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (pin_oe & pin_direction_q & ~pin_option_q & pin_data_q
        & ~alt_out_en) == '0)
        else $error("open drain drove high");
    a_pp_follows: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        ((pin_out ^ pin_data_q) & pin_direction_q & pin_option_q
        & ~alt_out_en) == '0)
        else $error("push pull level wrong");
    a_read_dir_back: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        rd_en && addr == GPP_ADDR_DIR |=>
        rdata[NPINS-1:0] == $past(pin_direction_q))
        else $error("direction readback wrong");
    a_read_data_view: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        rd_en && addr == GPP_ADDR_DATA |=>
        rdata[NPINS-1:0] == $past(data_view))
        else $error("data readback wrong");
    a_fetch_clears: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        vector_fetch[0] && !irq_d[0] |=> !irq_pend_q[0])
        else $error("fetch did not clear");
    a_pend_holds: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        irq_pend_q[0] && !vector_fetch[0] && !sens_wr |=> irq_pend_q[0])
        else $error("request dropped by itself");
    a_sens_clears: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        sens_wr && irq_d == '0 |=> irq_pend_q == '0)
        else $error("sensitivity write did not clear");
    a_event_sets: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        irq_d[0] |=> irq_pend_q[0] [*1])
        else $error("event lost");
    a_mask_blocks: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        cpu_irq_mask |-> ext_irq_req == '0)
        else $error("masked request seen");
    a_alt_in_latch: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        ((alt_in ^ pin_data_q) & pin_direction_q) == '0)
        else $error("peripheral input wrong");
    a_pullup_input: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (pin_pullup_en & (pin_direction_q | alt_out_en)) == '0)
        else $error("pull-up on driven pin");
    a_alt_od_release: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (pin_oe & alt_out_en & alt_open_drain & alt_out) == '0)
        else $error("open drain peripheral drove high");

    c_irq_raised: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_pend_q[0] ##1 vector_fetch[0]);
    c_alt_drive: cover property (@(posedge ref_clk) disable iff (!rst_n)
        alt_out_en[0] && pin_oe[0]);
    c_od_release: cover property (@(posedge ref_clk) disable iff (!rst_n)
        pin_direction_q[0] && !pin_option_q[0] && pin_data_q[0]);
    c_set_over_clear: cover property (@(posedge ref_clk)
        disable iff (!rst_n) irq_d[0] && vector_fetch[0]);
    c_masked_pending: cover property (@(posedge ref_clk)
        disable iff (!rst_n) cpu_irq_mask && irq_pend_q != '0);
endmodule

// [hdl/gpp_pkg.sv]
package gpp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int GPP_AW = 2;
    localparam logic [1:0] GPP_ADDR_DATA = 2'h0;
    localparam logic [1:0] GPP_ADDR_DIR = 2'h1;
    localparam logic [1:0] GPP_ADDR_OPT = 2'h2;
    localparam logic [1:0] GPP_ADDR_SENS = 2'h3;
    localparam int GPP_PINS = 8;
    localparam logic [7:0] GPP_RST_BYTE = 8'h00;
    // sensitivity codes, two bits per vector group
    localparam logic [1:0] GPP_SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] GPP_SENS_RISE = 2'h1;
    localparam logic [1:0] GPP_SENS_FALL = 2'h2;
    localparam logic [1:0] GPP_SENS_BOTH = 2'h3;
endpackage

// [hdl/gpp_pin_sync.sv]
`timescale 1ns/100ps
module gpp_pin_sync
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // meta_q is read only by the second stage
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [test/gpp_pad_model.sv]
`timescale 1ns/100ps
module gpp_pad_model
#(
    parameter int N = 8
)
(
    input wire logic ref_clk,
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe,
    input wire logic [N-1:0] pin_pullup_en,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pin_lvl
);
    logic [N-1:0] last_q;
    always_ff @(posedge ref_clk)
    begin
        last_q <= pin_lvl;
    end
    // undriven pads wander so a stale level never passes
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (pin_oe[i])
                pin_lvl[i] = pin_out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pin_pullup_en[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = ~last_q[i];
        end
    end
endmodule

// [test/gpp_port_tb_top.sv]
`timescale 1ns/100ps
module gpp_port_tb_top;
    import gpp_pkg::*;
    logic ref_clk = 0;
    logic rst_n = 0;
    logic [1:0] addr = 0;
    logic [7:0] wdata = 0;
    logic wr_en = 0;
    logic rd_en = 0;
    logic cpu_irq_mask = 0;
    logic [7:0] rdata, pin_in, pin_out, pin_oe, pin_pullup_en, alt_in;
    logic [7:0] alt_out_en = 0;
    logic [7:0] alt_out = 0;
    logic [7:0] alt_open_drain = 0;
    logic [7:0] ev = 8'hff;
    logic [7:0] een = 8'hff;
    logic [1:0] vector_fetch = 0;
    logic [1:0] ext_irq_req;
    int seed = 88855;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    // pins 0-3 on group 0, pins 4-7 on group 1
    gpp_port #(.NGRP(2), .GRP_MAP(16'h5500)) gpp_port_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .alt_out_en(alt_out_en),
        .alt_out(alt_out), .alt_open_drain(alt_open_drain),
        .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask),
        .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req));
    gpp_pad_model gpp_pad_model_i (
        .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .ext_en(een),
        .ext_val(ev), .pin_lvl(pin_in));
    always #25 ref_clk = ~ref_clk;
    task automatic report_and_stop;
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [39:0] g, input logic [39:0] x);
        total_checks++;
        if (g !== x)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] x);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        chk({32'h0, rdata}, {32'h0, x});
    endtask
    // d dir, o data, q option, v pad, a/x/w alternate claim/value/od
    function automatic logic [39:0] exp_f(input logic [7:0] d, o, q,
        v, a, x, w);
        logic [7:0] oe, ou, pd;
        oe = (a & (~w | ~x)) | (~a & d & (q | ~o));
        ou = oe & ((a & x & ~w) | (~a & q & o));
        pd = (oe & ou) | (~oe & v);
        return {oe, ou, ~d & q, (d & o) | (~d & a & x) | (~d & ~a & pd),
            (d & o) | (~d & pd)};
    endfunction
    function automatic logic [39:0] irq_exp(input logic hit, input int g);
        return hit ? 40'h1 << g : 40'h0;
    endfunction
    initial
    begin
        logic [7:0] d, o, q;
        logic [39:0] e;
        logic [1:0] x;
        int g;
        int p;
        step(6);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({22'h0, pin_oe, pin_pullup_en, ext_irq_req}, 40'h0);
        rd_chk(GPP_ADDR_DIR, GPP_RST_BYTE);
        rd_chk(GPP_ADDR_OPT, GPP_RST_BYTE);
        rd_chk(GPP_ADDR_SENS, GPP_RST_BYTE);
        step(1);
        een <= 8'h00;
        wr_reg(GPP_ADDR_OPT, 8'hff);
        step(3);
        rd_chk(GPP_ADDR_DATA, 8'hff);
        step(1);
        een <= 8'hff;
        repeat (40)
        begin
            d = 8'($random(seed));
            o = 8'($random(seed));
            q = 8'($random(seed));
            // whole-byte writes, data before direction
            wr_reg(GPP_ADDR_DATA, o);
            wr_reg(GPP_ADDR_OPT, q);
            wr_reg(GPP_ADDR_DIR, d);
            step(1);
            ev <= 8'($random(seed));
            // no claim on interrupt inputs, released claimed pins take the external level
            alt_out_en <= 8'($random(seed)) & ~(~d & q);
            alt_out <= 8'($random(seed));
            alt_open_drain <= 8'($random(seed));
            step(3);
            @(negedge ref_clk);
            e = exp_f(d, o, q, ev, alt_out_en, alt_out, alt_open_drain);
            chk({pin_oe, pin_out & pin_oe, pin_pullup_en, 8'h0, alt_in},
                e & 40'hffffff00ff);
            rd_chk(GPP_ADDR_DATA, e[15:8]);
        end
        step(1);
        alt_out_en <= 8'h00;
        ev <= 8'hff;
        // mid-run reset: latch and setup must start over
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({22'h0, pin_oe, pin_pullup_en, ext_irq_req}, 40'h0);
        wr_reg(GPP_ADDR_DIR, 8'hff);
        rd_chk(GPP_ADDR_DATA, GPP_RST_BYTE);
        chk({24'h0, pin_oe, pin_out}, 40'hff00);
        wr_reg(GPP_ADDR_OPT, 8'hff);
        wr_reg(GPP_ADDR_DIR, 8'h00);
        // released pins need the sync delay before the first clear
        step(3);
        for (int m = 0; m < 4; m++)
        begin
            g = m % 2;
            p = g ? 6 : 2;
            x = m[1:0];
            wr_reg(GPP_ADDR_SENS, {4{x}});
            step(1);
            ev[p] <= 1'b0;
            step(4);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, irq_exp(m != 1, g));
            step(1);
            vector_fetch[g] <= 1'b1;
            step(1);
            vector_fetch <= 2'h0;
            step(2);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, irq_exp(m == 0, g));
            step(1);
            ev[p] <= 1'b1;
            step(4);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, irq_exp(m != 2, g));
            step(1);
            cpu_irq_mask <= 1'b1;
            step(1);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, 40'h0);
            step(1);
            cpu_irq_mask <= 1'b0;
            step(1);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, irq_exp(m != 2, g));
            wr_reg(GPP_ADDR_SENS, {4{x}});
            step(1);
            @(negedge ref_clk);
            chk({38'h0, ext_irq_req}, 40'h0);
        end
        report_and_stop;
    end
endmodule
